// [src/rcri_regs.svh]
// register map, field positions, reset values and timing counts
// assumes a 32-bit apb slave with word-aligned byte addresses
`ifndef RCRI_REGS_SVH
`define RCRI_REGS_SVH
`define RCRI_OFS_CFG     8'h00
`define RCRI_OFS_PAD     8'h04
`define RCRI_OFS_ALCFG   8'h08
`define RCRI_OFS_VAL     8'h0C
`define RCRI_OFS_ALVAL   8'h10
`define RCRI_OFS_KEY     8'h14
`define RCRI_BIT_ON      15
`define RCRI_BIT_UNLOCK  13
`define RCRI_BIT_SYNC    12
`define RCRI_BIT_HALF    11
`define RCRI_BIT_OUTEN   10
`define RCRI_PTR_HI      9
`define RCRI_PTR_LO      8
`define RCRI_BIT_SECSEL  1
`define RCRI_BIT_TTL     0
`define RCRI_KEY_FIRST   8'h55
`define RCRI_KEY_SECOND  8'hAA
`define RCRI_PRE_LAST    17'h07FFF
`define RCRI_SYNC_WIN    17'h0001F
`define RCRI_RST_MTH     5'h01
`define RCRI_RST_DAY     6'h01
`endif

// [src/rcri_pkg.sv]
// types of the clock and calendar register block
// assumes rcri_regs.svh holds all numbers
package rcri_pkg;
    // unlock key sequence progress
    typedef enum logic [1:0] {KEY_IDLE, KEY_55, KEY_OPEN} rcri_key_e;
    // whole state of the top module
    typedef struct packed {
        logic               on;
        logic               unlock;
        logic               out_en;
        logic [1:0]         vptr;
        logic [7:0]         cal;
        logic               sec_sel;
        logic               ttl_sel;
        logic               arm;
        logic               endless;
        logic [3:0]         mask;
        logic [1:0]         aptr;
        logic [7:0]         rpt;
        logic [7:0]         yr;
        logic [4:0]         mth;
        logic [5:0]         day;
        logic [2:0]         wd;
        logic [5:0]         hr;
        logic [6:0]         mi;
        logic [6:0]         se;
        logic [4:0]         amth;
        logic [5:0]         aday;
        logic [2:0]         awd;
        logic [5:0]         ahr;
        logic [6:0]         ami;
        logic [6:0]         ase;
        rcri_key_e          key;
        logic [2:0]         xs;
        logic               xl;
        logic signed [16:0] pre;
        logic               sec_d;
        logic               half_d;
        logic               al_pulse;
        logic               rdy;
        logic               err;
        logic [31:0]        rdata;
        logic               pin;
        logic               pin_oe_n;
        logic               ttl_o;
    } rcri_state_s;
endpackage

// [src/rcri_top.sv]
// clock and calendar register block with apb slave and crystal timekeeping
// assumes one 40 MHz clock; the crystal arrives as a slow asynchronous pin
//
// Register access over APB and the register offsets were decided locally.
`include "rcri_regs.svh"

module rcri_top #(
    parameter logic [16:0] SEC_LAST = `RCRI_PRE_LAST  // crystal ticks per second less one
) (
    input  wire logic        CLOCK_IN,     // 40 MHz system clock
    input  wire logic        SRST_IN,      // power-on reset, sync
    input  wire logic        SYS_RST_IN,   // other reset, sync
    input  wire logic        XTAL_IN,      // 32.768 kHz crystal level
    input  wire logic        PSEL_IN,      // apb select
    input  wire logic        PENABLE_IN,   // apb enable
    input  wire logic        PWRITE_IN,    // apb direction
    input  wire logic [7:0]  PADDR_IN,     // apb byte address
    input  wire logic [31:0] PWDATA_IN,    // apb write data
    input  wire logic [3:0]  PSTRB_IN,     // apb byte strobes
    output logic      [31:0] PRDATA_OUT,   // apb read data
    output logic             PREADY_OUT,   // apb ready
    output logic             PSLVERR_OUT,  // apb error
    output logic             PIN_OUT,      // clock pin level
    output logic             PIN_OE_N_OUT, // clock pin enable, low drives
    output logic             TTL_SEL_OUT   // parallel port input select
);
    import rcri_pkg::*;

    localparam rcri_state_s RST_S = '{mth: `RCRI_RST_MTH, day: `RCRI_RST_DAY,
                                      key: KEY_IDLE, default: '0};

    rcri_state_s s;
    rcri_state_s n;
    logic        acc;
    logic        done;
    logic        wr;
    logic        rd;
    logic        tick;
    logic        sec_evt;
    logic        min_evt;
    logic        half;
    logic        sync;
    logic        hit;
    logic        amatch;
    logic [8:0]  c;
    logic [15:0] rv;
    logic [7:0]  dlast;

    // step a bcd pair; carry set when it wraps from last to first
    function automatic logic [8:0] bcd_step(input logic [7:0] v,
                                            input logic [7:0] last,
                                            input logic [7:0] first);
        if (v == last) begin
            bcd_step = {1'h1, first};
        end else if (v[3:0] == 4'h9) begin
            bcd_step = {1'h0, v[7:4] + 4'h1, 4'h0};
        end else begin
            bcd_step = {1'h0, v + 8'h01};
        end
    endfunction

    // last day of month; every year divisible by four is a leap year here
    function automatic logic [7:0] month_last(input logic [4:0] mo, input logic [7:0] y);
        logic leap;
        leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                    : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
        case (mo)
            5'h02:   month_last = leap ? 8'h29 : 8'h28;
            5'h04, 5'h06, 5'h09, 5'h11: month_last = 8'h30;
            default: month_last = 8'h31;
        endcase
    endfunction

    // window word for a pointer value, unused bits zero
    function automatic logic [15:0] win_word(input logic [1:0] p, input logic [6:0] mi,
                                             input logic [6:0] se, input logic [2:0] w,
                                             input logic [5:0] h, input logic [4:0] mo,
                                             input logic [5:0] d, input logic [7:0] y);
        case (p)
            2'h0:    win_word = {1'h0, mi, 1'h0, se};
            2'h1:    win_word = {5'h00, w, 2'h0, h};
            2'h2:    win_word = {3'h0, mo, 2'h0, d};
            default: win_word = {8'h00, y};
        endcase
    endfunction

    // next state: bus, crystal, calendar, alarm, then software writes
    always_comb begin
        n = s;
        acc = PSEL_IN & PENABLE_IN & ~s.rdy;
        done = PSEL_IN & PENABLE_IN & s.rdy;
        wr = done & PWRITE_IN;
        rd = done & ~PWRITE_IN;
        n.xs = {s.xs[1:0], XTAL_IN};
        if (s.xs[1] == s.xs[2]) begin
            n.xl = s.xs[2];
        end
        tick = (s.xs[1] == s.xs[2]) & s.xs[2] & ~s.xl;
        half = ~s.pre[16] & (s.pre > $signed({1'h0, SEC_LAST[16:1]}));
        sync = ~s.pre[16] & (s.pre >= $signed(SEC_LAST - `RCRI_SYNC_WIN));
        sec_evt = s.on & tick & (s.pre == $signed(SEC_LAST));
        min_evt = sec_evt & (s.se == 7'h59);
        dlast = month_last(s.mth, s.yr);
        c = 9'h000;
        if (s.on & tick) begin
            n.pre = s.pre + 17'sh00001;
        end
        if (sec_evt) begin
            n.pre = 17'sh00000;
            c = bcd_step({1'h0, s.se}, 8'h59, 8'h00);
            n.se = c[6:0];
            if (c[8]) begin
                n.pre = {{7{s.cal[7]}}, s.cal, 2'h0};
                c = bcd_step({1'h0, s.mi}, 8'h59, 8'h00);
                n.mi = c[6:0];
            end
            if (c[8]) begin
                c = bcd_step({2'h0, s.hr}, 8'h23, 8'h00);
                n.hr = c[5:0];
            end
            if (c[8]) begin
                n.wd = (s.wd == 3'h6) ? 3'h0 : s.wd + 3'h1;
                c = bcd_step({2'h0, s.day}, dlast, 8'h01);
                n.day = c[5:0];
            end
            if (c[8]) begin
                c = bcd_step({3'h0, s.mth}, 8'h12, 8'h01);
                n.mth = c[4:0];
            end
            if (c[8]) begin
                c = bcd_step(s.yr, 8'h99, 8'h00);
                n.yr = c[7:0];
            end
        end
        n.sec_d = sec_evt;
        n.half_d = half;
        // alarm compare one cycle after the time has advanced
        case (s.mask)
            4'h1:    amatch = 1'h1;
            4'h2:    amatch = s.se[3:0] == s.ase[3:0];
            4'h3:    amatch = s.se == s.ase;
            4'h4:    amatch = s.se == s.ase && s.mi[3:0] == s.ami[3:0];
            4'h5:    amatch = s.se == s.ase && s.mi == s.ami;
            4'h6:    amatch = s.se == s.ase && s.mi == s.ami && s.hr == s.ahr;
            4'h7:    amatch = s.se == s.ase && s.mi == s.ami && s.hr == s.ahr
                              && s.wd == s.awd;
            4'h8:    amatch = s.se == s.ase && s.mi == s.ami && s.hr == s.ahr
                              && s.day == s.aday;
            4'h9:    amatch = s.se == s.ase && s.mi == s.ami && s.hr == s.ahr
                              && s.day == s.aday && s.mth == s.amth;
            default: amatch = 1'h0;
        endcase
        hit = s.arm & ((s.mask == 4'h0 & s.on & (half != s.half_d)) | (s.sec_d & amatch));
        if (hit) begin
            n.al_pulse = ~s.al_pulse;
            if (s.rpt == 8'h00 && !s.endless) begin
                n.arm = 1'h0;
            end else begin
                n.rpt = s.rpt - 8'h01;
            end
        end
        case (PADDR_IN)
            `RCRI_OFS_CFG:   rv = {s.on, 1'h0, s.unlock, sync, half, s.out_en, s.vptr, s.cal};
            `RCRI_OFS_PAD:   rv = {14'h0000, s.sec_sel, s.ttl_sel};
            `RCRI_OFS_ALCFG: rv = {s.arm, s.endless, s.mask, s.aptr, s.rpt};
            `RCRI_OFS_VAL:   rv = win_word(s.vptr, s.mi, s.se, s.wd, s.hr, s.mth, s.day, s.yr);
            `RCRI_OFS_ALVAL: rv = (s.aptr == 2'h3) ? 16'h0000 :
                             win_word(s.aptr, s.ami, s.ase, s.awd, s.ahr, s.amth, s.aday, 8'h00);
            default:         rv = 16'h0000;
        endcase
        // registered ready: one wait state, data captured with it
        n.rdy = acc;
        n.err = 1'h0;
        if (acc) begin
            n.rdata = {16'h0000, rv};
            n.err = !(PADDR_IN inside {`RCRI_OFS_CFG, `RCRI_OFS_PAD, `RCRI_OFS_ALCFG,
                                       `RCRI_OFS_VAL, `RCRI_OFS_ALVAL, `RCRI_OFS_KEY});
        end
        // key sequence; any other completed access closes the window
        if (done) begin
            n.key = KEY_IDLE;
            if (wr && PADDR_IN == `RCRI_OFS_KEY && PSTRB_IN[0]) begin
                if (PWDATA_IN[7:0] == `RCRI_KEY_FIRST) begin
                    n.key = KEY_55;
                end else if (PWDATA_IN[7:0] == `RCRI_KEY_SECOND && s.key == KEY_55) begin
                    n.key = KEY_OPEN;
                end
            end
        end
        if (wr && PADDR_IN == `RCRI_OFS_CFG) begin
            if (PSTRB_IN[0]) begin
                n.cal = PWDATA_IN[7:0];
            end
            if (PSTRB_IN[1]) begin
                n.out_en = PWDATA_IN[`RCRI_BIT_OUTEN];
                n.vptr = PWDATA_IN[`RCRI_PTR_HI:`RCRI_PTR_LO];
                n.unlock = PWDATA_IN[`RCRI_BIT_UNLOCK] & (s.unlock | (s.key == KEY_OPEN));
                if (s.unlock) begin
                    n.on = PWDATA_IN[`RCRI_BIT_ON];
                end
            end
        end
        if (wr && PADDR_IN == `RCRI_OFS_PAD && PSTRB_IN[0]) begin
            n.sec_sel = PWDATA_IN[`RCRI_BIT_SECSEL];
            n.ttl_sel = PWDATA_IN[`RCRI_BIT_TTL];
        end
        // software arming wins over a same-cycle disarm
        if (wr && PADDR_IN == `RCRI_OFS_ALCFG) begin
            if (PSTRB_IN[1]) begin
                n.arm = PWDATA_IN[15];
                n.endless = PWDATA_IN[14];
                n.mask = PWDATA_IN[13:10];
                n.aptr = PWDATA_IN[9:8];
            end
            if (PSTRB_IN[0]) begin
                n.rpt = PWDATA_IN[7:0];
            end
        end
        if (wr && PADDR_IN == `RCRI_OFS_VAL && s.unlock) begin
            case (s.vptr)
                2'h0: begin
                    if (PSTRB_IN[1]) begin
                        n.mi = PWDATA_IN[14:8];
                    end
                    if (PSTRB_IN[0]) begin
                        n.se = PWDATA_IN[6:0];
                        n.pre = 17'sh00000;
                    end
                end
                2'h1: begin
                    if (PSTRB_IN[1]) begin
                        n.wd = PWDATA_IN[10:8];
                    end
                    if (PSTRB_IN[0]) begin
                        n.hr = PWDATA_IN[5:0];
                    end
                end
                2'h2: begin
                    if (PSTRB_IN[1]) begin
                        n.mth = PWDATA_IN[12:8];
                    end
                    if (PSTRB_IN[0]) begin
                        n.day = PWDATA_IN[5:0];
                    end
                end
                default: begin
                    if (PSTRB_IN[0]) begin
                        n.yr = PWDATA_IN[7:0];
                    end
                end
            endcase
        end
        // alarm window writes are not locked
        if (wr && PADDR_IN == `RCRI_OFS_ALVAL) begin
            case (s.aptr)
                2'h0: begin
                    n.ami = PSTRB_IN[1] ? PWDATA_IN[14:8] : s.ami;
                    n.ase = PSTRB_IN[0] ? PWDATA_IN[6:0] : s.ase;
                end
                2'h1: begin
                    n.awd = PSTRB_IN[1] ? PWDATA_IN[10:8] : s.awd;
                    n.ahr = PSTRB_IN[0] ? PWDATA_IN[5:0] : s.ahr;
                end
                2'h2: begin
                    n.amth = PSTRB_IN[1] ? PWDATA_IN[12:8] : s.amth;
                    n.aday = PSTRB_IN[0] ? PWDATA_IN[5:0] : s.aday;
                end
                default: begin
                    n.aday = s.aday;
                end
            endcase
        end
        if (((rd || (wr && PSTRB_IN[1])) && PADDR_IN == `RCRI_OFS_VAL) && s.vptr != 2'h0) begin
            n.vptr = s.vptr - 2'h1;
        end
        if (((rd || (wr && PSTRB_IN[1])) && PADDR_IN == `RCRI_OFS_ALVAL) && s.aptr != 2'h0) begin
            n.aptr = s.aptr - 2'h1;
        end
        n.pin = s.out_en & (s.sec_sel ? half : s.al_pulse);
        n.pin_oe_n = ~s.out_en;
        n.ttl_o = s.ttl_sel;
        // other reset spares the cfg register, alarm window values and time; pad and alarm configuration clear
        if (SYS_RST_IN) begin
            n.key = KEY_IDLE;
            n.sec_sel = 1'h0;
            n.ttl_sel = 1'h0;
            n.arm = 1'h0;
            n.endless = 1'h0;
            n.mask = 4'h0;
            n.aptr = 2'h0;
            n.rpt = 8'h00;
            n.rdy = 1'h0;
            n.err = 1'h0;
        end
    end

    // single state register, power-on reset only here
    always_ff @(posedge CLOCK_IN) begin
        if (SRST_IN) begin
            s <= RST_S;
        end else begin
            s <= n;
        end
    end

    // outputs straight from state
    assign PRDATA_OUT = s.rdata;
    assign PREADY_OUT = s.rdy;
    assign PSLVERR_OUT = s.err;
    assign PIN_OUT = s.pin;
    assign PIN_OE_N_OUT = s.pin_oe_n;
    assign TTL_SEL_OUT = s.ttl_o;

    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (SRST_IN);

    property p_lock;
        wr && !SYS_RST_IN && PADDR_IN == `RCRI_OFS_VAL && !s.unlock && !sec_evt
            |=> $stable(s.yr) && $stable(s.mth) && $stable(s.day);
    endproperty
    a_lock: assert property (p_lock) else $error("locked value write changed time");
    property p_key;
        $rose(s.unlock) |-> $past(s.key) == KEY_OPEN;
    endproperty
    a_key: assert property (p_key) else $error("unlock set without key");
    property p_on;
        $changed(s.on) |-> $past(s.unlock);
    endproperty
    a_on: assert property (p_on) else $error("enable changed while locked");
    property p_half;
        wr && !SYS_RST_IN && PADDR_IN == `RCRI_OFS_VAL && s.unlock && s.vptr == 2'h0
            && PSTRB_IN[0] |=> !half ##1 PRDATA_OUT[`RCRI_BIT_HALF] == 1'h0 || !s.rdy;
    endproperty
    a_half: assert property (p_half) else $error("half flag not cleared");
    property p_ptr;
        rd && PADDR_IN == `RCRI_OFS_VAL && s.vptr != 2'h0 && !SYS_RST_IN
            |=> s.vptr == $past(s.vptr) - 2'h1;
    endproperty
    a_ptr: assert property (p_ptr) else $error("pointer did not step");
    property p_trim;
        min_evt && !(wr && PADDR_IN == `RCRI_OFS_VAL)
            |=> s.pre == {{7{$past(s.cal[7])}}, $past(s.cal), 2'h0};
    endproperty
    a_trim: assert property (p_trim) else $error("minute trim not loaded");
    property p_pin;
        ##1 PIN_OUT == ($past(s.out_en) & ($past(s.sec_sel) ? $past(half) : $past(s.al_pulse)));
    endproperty
    a_pin: assert property (p_pin) else $error("pin source wrong");
    property p_pad;
        acc && PADDR_IN == `RCRI_OFS_PAD |=> PREADY_OUT && PRDATA_OUT[31:2] == 30'h00000000;
    endproperty
    a_pad: assert property (p_pad) else $error("pad unused bits not zero");
    property p_disarm;
        hit && s.rpt == 8'h00 && !s.endless && !wr && !SYS_RST_IN |=> !s.arm;
    endproperty
    a_disarm: assert property (p_disarm) else $error("alarm not disarmed");
endmodule

// [verif/tb_rcri_top.sv]
// register-level bench for the clock and calendar block, apb master tasks only
// assumes rcri_regs.svh offsets; short second via SEC_LAST so the calendar rolls quickly
`include "rcri_regs.svh"

module tb_rcri_top;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [16:0] SEC_LAST_TB = 17'd63;   // 64 crystal ticks per second
    localparam logic [31:0] ALL         = 32'hFFFFFFFF;

    logic        clk;
    logic        srst;
    logic        sys_rst;
    logic        xtal;
    logic        xtal_run;
    logic [7:0]  xcnt;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        pin;
    logic        pin_oe_n;
    logic        ttl_sel;
    logic [31:0] rv;
    logic        ev;
    int          err_total;
    int          num_checks;
    int          cyc;

    rcri_top #(.SEC_LAST(SEC_LAST_TB)) u_dut (
        .CLOCK_IN     (clk),
        .SRST_IN      (srst),
        .SYS_RST_IN   (sys_rst),
        .XTAL_IN      (xtal),
        .PSEL_IN      (psel),
        .PENABLE_IN   (penable),
        .PWRITE_IN    (pwrite),
        .PADDR_IN     (paddr),
        .PWDATA_IN    (pwdata),
        .PSTRB_IN     (pstrb),
        .PRDATA_OUT   (prdata),
        .PREADY_OUT   (pready),
        .PSLVERR_OUT  (pslverr),
        .PIN_OUT      (pin),
        .PIN_OE_N_OUT (pin_oe_n),
        .TTL_SEL_OUT  (ttl_sel)
    );

    // free-running system clock, 25 ns period
    always #12.5 clk = ~clk;

    // crystal stand-in toggles every 4 cycles, held still when stopped
    always @(posedge clk) begin
        xcnt <= xcnt + 8'h01;
        if (xtal_run && (xcnt[1:0] == 2'h3)) begin
            xtal <= ~xtal;
        end
    end

    // hang guard, well above the roughly 1350 cycles the tests need
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total = err_total + 1;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks = num_checks + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= w ? s : 4'h0;
        @(posedge clk);
        penable <= 1'b1;
        // only pready or the hang guard ends this wait
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        xfer(1'b1, a, d, s);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                      input string nm);
        xfer(1'b0, a, 32'h0, 4'h0);
        chk(nm, e, rv & m);
    endtask

    task automatic unlock(input logic [31:0] cfg);
        wr(`RCRI_OFS_KEY, 32'h55, 4'h1);
        wr(`RCRI_OFS_KEY, 32'hAA, 4'h1);
        wr(`RCRI_OFS_CFG, cfg, 4'h3);
    endtask

    // main sequence: reset values, lock, pointer, layout, timekeeping, partial reset
    initial begin
        clk = 0; srst = 1; sys_rst = 0; xtal = 0; xtal_run = 0; xcnt = 0; cyc = 0;
        psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; pstrb = 0;
        err_total = 0; num_checks = 0;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        rd(`RCRI_OFS_CFG, ALL, 32'h0, "cfg reset");
        rd(`RCRI_OFS_PAD, ALL, 32'h0, "pad reset");
        rd(`RCRI_OFS_ALCFG, ALL, 32'h0, "alarm cfg reset");
        rd(`RCRI_OFS_KEY, ALL, 32'h0, "key read");
        rd(8'h18, ALL, 32'h0, "unmapped read");
        chk("unmapped error", 32'h1, {31'h0, ev});
        chk("pin enable off", 32'h1, {31'h0, pin_oe_n});
        // locked value write still steps the pointer
        wr(`RCRI_OFS_CFG, 32'h0300, 4'h3);
        wr(`RCRI_OFS_VAL, 32'h0012, 4'h3);
        rd(`RCRI_OFS_CFG, ALL, 32'h0200, "ptr after write");
        wr(`RCRI_OFS_CFG, 32'h0300, 4'h3);
        rd(`RCRI_OFS_VAL, ALL, 32'h0000, "year locked");
        rd(`RCRI_OFS_VAL, ALL, 32'h0101, "month day reset");
        rd(`RCRI_OFS_VAL, ALL, 32'h0000, "weekday hour reset");
        rd(`RCRI_OFS_VAL, ALL, 32'h0000, "min sec reset");
        rd(`RCRI_OFS_CFG, ALL, 32'h0000, "ptr stops at zero");
        // key sequence broken by an extra access must not unlock
        wr(`RCRI_OFS_KEY, 32'h55, 4'h1);
        wr(`RCRI_OFS_KEY, 32'hAA, 4'h1);
        rd(`RCRI_OFS_PAD, ALL, 32'h0, "pad between");
        wr(`RCRI_OFS_CFG, 32'hA000, 4'h3);
        rd(`RCRI_OFS_CFG, ALL, 32'h0, "late unlock refused");
        unlock(32'h2380);
        rd(`RCRI_OFS_CFG, ALL, 32'h2380, "unlock and trim");
        // all four windows written, unused bits set on purpose
        wr(`RCRI_OFS_VAL, 32'hFF99, 4'h3);
        wr(`RCRI_OFS_VAL, 32'hF231, 4'h3);
        wr(`RCRI_OFS_VAL, 32'hFEE3, 4'h3);
        wr(`RCRI_OFS_VAL, 32'hD9D8, 4'h3);
        wr(`RCRI_OFS_CFG, 32'h2300, 4'h3);
        rd(`RCRI_OFS_VAL, ALL, 32'h0099, "year value");
        rd(`RCRI_OFS_VAL, ALL, 32'h1231, "month day value");
        rd(`RCRI_OFS_VAL, ALL, 32'h0623, "weekday hour value");
        rd(`RCRI_OFS_VAL, ALL, 32'h5958, "min sec value");
        wr(`RCRI_OFS_PAD, 32'hFFFF, 4'h3);
        rd(`RCRI_OFS_PAD, ALL, 32'h0003, "pad bits");
        chk("ttl select", 32'h1, {31'h0, ttl_sel});
        // trim of four steps: the minute rollover reloads 16 ticks
        wr(`RCRI_OFS_CFG, 32'hA404, 4'h3);
        rd(`RCRI_OFS_CFG, ALL, 32'hA404, "module on");
        chk("pin enable on", 32'h0, {31'h0, pin_oe_n});
        // second half reached, then cleared by a low-byte write
        wr(`RCRI_OFS_VAL, 32'h0059, 4'h1);
        xtal_run <= 1'b1;
        repeat (400) @(posedge clk);
        xtal_run <= 1'b0;
        repeat (10) @(posedge clk);
        rd(`RCRI_OFS_CFG, 32'h1800, 32'h1800, "half and ripple set");
        chk("pin seconds clock", 32'h1, {31'h0, pin});
        wr(`RCRI_OFS_VAL, 32'h0059, 4'h1);
        rd(`RCRI_OFS_CFG, 32'h1800, 32'h0, "half cleared");
        // single-shot half-second alarm, weekday-hour alarm pair stored
        wr(`RCRI_OFS_ALCFG, 32'h8100, 4'h3);
        wr(`RCRI_OFS_ALVAL, 32'h0312, 4'h3);
        wr(`RCRI_OFS_ALCFG, 32'h8100, 4'h3);
        // one second from 2099-12-31 23:59:59 rolls every field
        xtal_run <= 1'b1;
        repeat (700) @(posedge clk);
        xtal_run <= 1'b0;
        repeat (10) @(posedge clk);
        // about 23 ticks past rollover: only the trim puts pre past half
        rd(`RCRI_OFS_CFG, 32'h1800, 32'h1800, "trim applied");
        rd(`RCRI_OFS_ALVAL, ALL, 32'h0312, "alarm weekday hour");
        rd(`RCRI_OFS_ALCFG, ALL, 32'h0000, "alarm disarmed");
        wr(`RCRI_OFS_CFG, 32'hA700, 4'h3);
        rd(`RCRI_OFS_VAL, ALL, 32'h0000, "year rolled");
        rd(`RCRI_OFS_VAL, ALL, 32'h0101, "date rolled");
        rd(`RCRI_OFS_VAL, ALL, 32'h0000, "hour rolled");
        rd(`RCRI_OFS_VAL, ALL, 32'h0000, "time rolled");
        // restart the second, then drop the unlock once updates are done
        wr(`RCRI_OFS_VAL, 32'h0000, 4'h1);
        wr(`RCRI_OFS_CFG, 32'h8400, 4'h3);
        // the other reset keeps the cfg register but clears pad control
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        rd(`RCRI_OFS_PAD, ALL, 32'h0, "pad after reset");
        rd(`RCRI_OFS_CFG, ALL, 32'h8400, "cfg kept");
        chk("ttl after reset", 32'h0, {31'h0, ttl_sel});
        conclude();
    end
endmodule
